// ### rtl/acfg_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "acfg_params.svh"

module acfg_ctrl #(
  parameter int SCLK_HALF = `ACFG_SCLK_HALF_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link
  acfg_if.ctrl bus
);

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

  typedef struct packed {
    logic aw_have;
    logic [3:0] awaddr;
    logic w_have;
    logic [15:0] wdata;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    acfg_pkg::acfg_ctrl_state_t st;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [15:0] tx;
    logic [7:0] rx;
    logic sel_n;
    logic sclk;
    logic sdo;
  } acfg_ctrl_regs_t;

  acfg_ctrl_regs_t q, d;
  logic busy;

  assign busy = (q.st != acfg_pkg::ACFG_ST_IDLE);

  always_comb begin
    d = q;
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata[15:0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = `ACFG_RESP_OKAY;
      case (s_axi_araddr[3:0])
        `ACFG_AXI_CMD: d.rdata = {16'h0000, q.tx};
        `ACFG_AXI_STATUS: d.rdata = {16'h0000, q.rx, 7'h00, busy};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = `ACFG_RESP_SLVERR;
        end
      endcase
    end

    case (q.st)
      acfg_pkg::ACFG_ST_IDLE: begin
        d.sel_n = 1'b1;
        d.sclk = 1'b1;
      end
      acfg_pkg::ACFG_ST_SHIFT: begin
        if (q.div != 8'h00) begin
          d.div = q.div - 8'h01;
        end else begin
          d.div = HALF_LAST;
          if (q.sclk) begin
            d.sclk = 1'b0;
            if (q.bitn[3]) begin
              d.rx = {q.rx[6:0], bus.overrange_or_readback_pin};
            end
          end else begin
            d.sclk = 1'b1;
            if (q.bitn == 4'hF) begin
              d.st = acfg_pkg::ACFG_ST_END;
            end else begin
              d.bitn = q.bitn + 4'h1;
              d.tx = {q.tx[14:0], 1'b0};
              d.sdo = q.tx[14];
            end
          end
        end
      end
      acfg_pkg::ACFG_ST_END: begin
        if (q.div != 8'h00) begin
          d.div = q.div - 8'h01;
        end else begin
          d.sel_n = 1'b1;
          d.st = acfg_pkg::ACFG_ST_IDLE;
        end
      end
      default: d.st = acfg_pkg::ACFG_ST_IDLE;
    endcase

    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `ACFG_RESP_OKAY;
      if (q.awaddr == `ACFG_AXI_CMD) begin
        // A command while busy is dropped; software polls busy first
        if (!busy) begin
          d.st = acfg_pkg::ACFG_ST_SHIFT;
          d.tx = q.wdata;
          d.sdo = q.wdata[15];
          d.sel_n = 1'b0;
          d.sclk = 1'b1;
          d.bitn = 4'h0;
          d.div = HALF_LAST;
        end
      end else if (q.awaddr != `ACFG_AXI_STATUS) begin
        d.bresp = `ACFG_RESP_SLVERR;
      end
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= acfg_pkg::ACFG_ST_IDLE;
      q.sel_n <= 1'b1;
      q.sclk <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign bus.serial_select_n = q.sel_n;
  assign bus.serial_clock = q.sclk;
  assign bus.serial_data_in = q.sdo;

endmodule

`default_nettype wire

// ### rtl/acfg_device.sv
// Contract
// - Software-reset bit clears all registers, self-clears
// - Readback bit selects over-range or readback pin
// - Six-bit swing field selects output swing
// - Swing code applies only with swing enable
// - First performance field: 00 default, 11 best
// - Four-bit gain, half-dB steps, zero default
// - Gain applies only if enabled, digital path on
// - Pattern codes: normal, all zeros, all ones
// - Code 011 alternates 0101... and 1010...
// - Code 100 ramps one step per four cycles
// - Code 101 outputs custom twelve-bit word
// - Clock and data buffer drive bits
// - Format field: strap pin, twos, offset binary
// - Offset correction enable bit
// - One write updates all fields of register
// - Controller writes zero to unused bits
// - All registers read zero after reset
// - Controller sets both performance settings
// - Shift on select low, commit each sixteenth fall
// - Address byte first, then data byte
// - Readback blocks writes except register zero
// - Readback shifts register out MSB first
`timescale 1ns/1ps
`default_nettype none
`include "acfg_params.svh"

module acfg_device #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  acfg_if.device bus,
  // Converter side inputs
  input wire logic [WIDTH-1:0] adc_sample,
  input wire logic overrange_in,
  input wire logic format_strap_pin,
  // Data path
  output logic [WIDTH-1:0] data_word,
  // Effective configuration
  output logic [5:0] swing_code,
  output logic [1:0] first_performance_setting,
  output logic second_performance_setting,
  output logic [3:0] gain_code,
  output logic clock_buffer_drive,
  output logic data_buffer_drive,
  output logic twos_complement,
  output logic dc_correction_enable,
  output logic digital_path_enable,
  output logic standby,
  output logic power_down,
  output logic output_buffer_off
);

  localparam int NR = `ACFG_NUM_REGS;

  typedef struct packed {
    logic [NR-1:0][7:0] regs;
    logic sclk_q;
    logic [15:0] shift;
    logic [3:0] count;
    logic [7:0] readback;
    logic pin;
    logic [5:0] swing;
    logic [1:0] perf1;
    logic perf2;
    logic [3:0] gain;
    logic clk_drive;
    logic data_drive;
    logic twos;
    logic corr;
    logic dpath;
    logic stby;
    logic pdn;
    logic obuf_off;
  } acfg_dev_state_t;

  acfg_dev_state_t q, d;

  // Address to storage index, with valid flag and writable mask
  function automatic logic [12:0] lookup(input logic [7:0] a);
    logic [12:0] r;
    r = '0;
    case (a)
      `ACFG_A_RESET_READBACK: r = {1'b1, 4'd0, `ACFG_M_RESET_READBACK};
      `ACFG_A_SWING: r = {1'b1, 4'd1, `ACFG_M_SWING};
      `ACFG_A_PERF_FIRST: r = {1'b1, 4'd2, `ACFG_M_PERF_FIRST};
      `ACFG_A_GAIN_PATTERN: r = {1'b1, 4'd3, `ACFG_M_GAIN_PATTERN};
      `ACFG_A_BUF_STRENGTH: r = {1'b1, 4'd4, `ACFG_M_BUF_STRENGTH};
      `ACFG_A_FORMAT_OFFSET: r = {1'b1, 4'd5, `ACFG_M_FORMAT_OFFSET};
      `ACFG_A_CUSTOM_UPPER: r = {1'b1, 4'd6, `ACFG_M_CUSTOM_UPPER};
      `ACFG_A_CUSTOM_LOWER: r = {1'b1, 4'd7, `ACFG_M_CUSTOM_LOWER};
      `ACFG_A_IF_CLK_RISE: r = {1'b1, 4'd8, `ACFG_M_IF_CLK_RISE};
      `ACFG_A_CLK_FALL_STBY: r = {1'b1, 4'd9, `ACFG_M_CLK_FALL_STBY};
      `ACFG_A_PDN_SWING_EN: r = {1'b1, 4'd10, `ACFG_M_PDN_SWING_EN};
      `ACFG_A_PERF_SECOND: r = {1'b1, 4'd11, `ACFG_M_PERF_SECOND};
      `ACFG_A_PEDESTAL: r = {1'b1, 4'd12, `ACFG_M_PEDESTAL};
      `ACFG_A_OFFSET_LOOP: r = {1'b1, 4'd13, `ACFG_M_OFFSET_LOOP};
      `ACFG_A_SLOW_RATE: r = {1'b1, 4'd14, `ACFG_M_SLOW_RATE};
      default: r = '0;
    endcase
    return r;
  endfunction

  logic fall;
  logic readout;
  logic [15:0] word;
  logic [12:0] rd_hit;
  logic [12:0] wr_hit;
  logic [7:0] r_swing, r_gain, r_fmt, r_pdn, r_fall;

  assign fall = q.sclk_q & ~bus.serial_clock;
  assign readout = q.regs[0][`ACFG_B_READOUT];
  assign word = {q.shift[14:0], bus.serial_data_in};
  assign rd_hit = lookup(word[7:0]);
  assign wr_hit = lookup(word[15:8]);

  always_comb begin
    d = q;
    d.sclk_q = bus.serial_clock;
    if (bus.serial_select_n) begin
      // Partial words are dropped when select rises
      d.count = 4'h0;
    end else if (fall) begin
      d.shift = word;
      d.count = q.count + 4'h1;
      if (q.count == 4'h7) begin
        // Register zero is not readable; unmapped reads return zero
        d.readback = (rd_hit[12] && rd_hit[11:8] != 4'd0) ?
          q.regs[rd_hit[11:8]] : 8'h00;
      end else begin
        d.readback = {q.readback[6:0], 1'b0};
      end
      if (q.count == 4'hF && wr_hit[12] && (!readout || wr_hit[11:8] == 4'd0)) begin
        if (wr_hit[11:8] == 4'd0 && word[`ACFG_B_SWRESET]) begin
          // Reset bit is never stored, so it reads back cleared
          d.regs = '0;
        end else begin
          d.regs[wr_hit[11:8]] = word[7:0] & wr_hit[7:0];
        end
      end
    end
    d.pin = d.regs[0][`ACFG_B_READOUT] ? d.readback[7] : overrange_in;

    r_swing = d.regs[1];
    r_gain = d.regs[3];
    r_fmt = d.regs[5];
    r_fall = d.regs[9];
    r_pdn = d.regs[10];
    d.swing = `ACFG_SW_DEFAULT;
    if (r_pdn[1:0] == `ACFG_SWING_ON) begin
      case (r_swing[7:2])
        `ACFG_SW_410, `ACFG_SW_465, `ACFG_SW_570,
        `ACFG_SW_200, `ACFG_SW_125: d.swing = r_swing[7:2];
        default: d.swing = `ACFG_SW_DEFAULT;
      endcase
    end
    d.perf1 = (d.regs[2][1:0] == `ACFG_PERF_BEST) ? `ACFG_PERF_BEST : 2'h0;
    d.perf2 = d.regs[11][0];
    d.dpath = r_fall[`ACFG_B_DIGITAL_PATH];
    d.stby = r_fall[`ACFG_B_STANDBY];
    d.pdn = r_pdn[`ACFG_B_PDN_GLOBAL];
    d.obuf_off = r_pdn[`ACFG_B_PDN_OBUF];
    // Codes above 6 dB are undocumented and give no gain
    d.gain = (r_gain[`ACFG_B_GAIN_OFF] || !d.dpath || r_gain[7:4] > 4'hC) ?
      4'h0 : r_gain[7:4];
    d.clk_drive = d.regs[4][1];
    d.data_drive = d.regs[4][0];
    case (r_fmt[7:6])
      `ACFG_FMT_TWOS: d.twos = 1'b1;
      `ACFG_FMT_OFFSET: d.twos = 1'b0;
      default: d.twos = format_strap_pin;
    endcase
    d.corr = r_fmt[`ACFG_B_CORR_EN];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  acfg_pattern #(
    .WIDTH(WIDTH)
  ) u_pattern (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(q.regs[3][2:0]),
    .custom_word({q.regs[6], q.regs[7][7:4]}),
    .sample_word({adc_sample[WIDTH-1] ^ q.twos, adc_sample[WIDTH-2:0]}),
    .word_q(data_word)
  );

  assign bus.overrange_or_readback_pin = q.pin;
  assign swing_code = q.swing;
  assign first_performance_setting = q.perf1;
  assign second_performance_setting = q.perf2;
  assign gain_code = q.gain;
  assign clock_buffer_drive = q.clk_drive;
  assign data_buffer_drive = q.data_drive;
  assign twos_complement = q.twos;
  assign dc_correction_enable = q.corr;
  assign digital_path_enable = q.dpath;
  assign standby = q.stby;
  assign power_down = q.pdn;
  assign output_buffer_off = q.obuf_off;

endmodule

`default_nettype wire

// ### rtl/acfg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface acfg_if;
  logic serial_select_n;
  logic serial_clock;
  logic serial_data_in;
  logic overrange_or_readback_pin;

  modport device (
    input serial_select_n,
    input serial_clock,
    input serial_data_in,
    output overrange_or_readback_pin
  );

  modport ctrl (
    output serial_select_n,
    output serial_clock,
    output serial_data_in,
    input overrange_or_readback_pin
  );
endinterface

`default_nettype wire

// ### rtl/acfg_params.svh
`ifndef ACFG_PARAMS_SVH
`define ACFG_PARAMS_SVH

// Register addresses on the serial link
`define ACFG_A_RESET_READBACK 8'h00
`define ACFG_A_SWING 8'h01
`define ACFG_A_PERF_FIRST 8'h03
`define ACFG_A_GAIN_PATTERN 8'h25
`define ACFG_A_BUF_STRENGTH 8'h26
`define ACFG_A_FORMAT_OFFSET 8'h3D
`define ACFG_A_CUSTOM_UPPER 8'h3F
`define ACFG_A_CUSTOM_LOWER 8'h40
`define ACFG_A_IF_CLK_RISE 8'h41
`define ACFG_A_CLK_FALL_STBY 8'h42
`define ACFG_A_PDN_SWING_EN 8'h43
`define ACFG_A_PERF_SECOND 8'h4A
`define ACFG_A_PEDESTAL 8'hBF
`define ACFG_A_OFFSET_LOOP 8'hCF
`define ACFG_A_SLOW_RATE 8'hDF

// Writable bits per register; the rest are held at zero
`define ACFG_M_RESET_READBACK 8'h03
`define ACFG_M_SWING 8'hFC
`define ACFG_M_PERF_FIRST 8'h03
`define ACFG_M_GAIN_PATTERN 8'hFF
`define ACFG_M_BUF_STRENGTH 8'h03
`define ACFG_M_FORMAT_OFFSET 8'hE0
`define ACFG_M_CUSTOM_UPPER 8'hFF
`define ACFG_M_CUSTOM_LOWER 8'hF0
`define ACFG_M_IF_CLK_RISE 8'hFF
`define ACFG_M_CLK_FALL_STBY 8'hCC
`define ACFG_M_PDN_SWING_EN 8'h53
`define ACFG_M_PERF_SECOND 8'h01
`define ACFG_M_PEDESTAL 8'hF0
`define ACFG_M_OFFSET_LOOP 8'hBC
`define ACFG_M_SLOW_RATE 8'h30

`define ACFG_REG_RESET 8'h00
`define ACFG_NUM_REGS 15

// Field positions
`define ACFG_B_READOUT 0
`define ACFG_B_SWRESET 1
`define ACFG_B_GAIN_OFF 3
`define ACFG_B_DIGITAL_PATH 3
`define ACFG_B_STANDBY 2
`define ACFG_B_PDN_GLOBAL 6
`define ACFG_B_PDN_OBUF 4
`define ACFG_B_CORR_EN 5

// Documented swing, performance and format codes
`define ACFG_SW_DEFAULT 6'h00
`define ACFG_SW_410 6'h1B
`define ACFG_SW_465 6'h32
`define ACFG_SW_570 6'h14
`define ACFG_SW_200 6'h3E
`define ACFG_SW_125 6'h0F
`define ACFG_SWING_ON 2'h3
`define ACFG_PERF_BEST 2'h3
`define ACFG_FMT_STRAP 2'h0
`define ACFG_FMT_TWOS 2'h2
`define ACFG_FMT_OFFSET 2'h3

// Timing
`define ACFG_CLK_NS 8
`define ACFG_SCLK_MIN_HALF_NS 25
`define ACFG_SCLK_HALF_CYC \
  ((`ACFG_SCLK_MIN_HALF_NS + `ACFG_CLK_NS - 1) / `ACFG_CLK_NS)
`define ACFG_RAMP_STEP_CYC 4

// Controller AXI4-Lite map
`define ACFG_AXI_CMD 4'h0
`define ACFG_AXI_STATUS 4'h4
`define ACFG_RESP_OKAY 2'h0
`define ACFG_RESP_SLVERR 2'h2

`endif

// ### rtl/acfg_pattern.sv
`timescale 1ns/1ps
`default_nettype none
`include "acfg_params.svh"

module acfg_pattern #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Selection
  input wire logic [2:0] mode,
  input wire logic [WIDTH-1:0] custom_word,
  input wire logic [WIDTH-1:0] sample_word,
  // Result
  output logic [WIDTH-1:0] word_q
);

  typedef struct packed {
    logic [WIDTH-1:0] ramp;
    logic [1:0] step;
    logic toggle;
    logic [WIDTH-1:0] word;
  } acfg_pat_state_t;

  localparam logic [1:0] STEP_LAST = 2'(`ACFG_RAMP_STEP_CYC - 1);

  acfg_pat_state_t q, d;

  always_comb begin
    d = q;
    d.toggle = ~q.toggle;
    if (mode == acfg_pkg::ACFG_PAT_RAMP) begin
      d.step = q.step + 2'h1;
      if (q.step == STEP_LAST) begin
        d.ramp = q.ramp + 1'b1;
      end
    end else begin
      d.step = 2'h0;
      d.ramp = '0;
    end
    case (mode)
      acfg_pkg::ACFG_PAT_ZEROS: d.word = '0;
      acfg_pkg::ACFG_PAT_ONES: d.word = '1;
      acfg_pkg::ACFG_PAT_TOGGLE: d.word = {(WIDTH/2){q.toggle, ~q.toggle}};
      acfg_pkg::ACFG_PAT_RAMP: d.word = q.ramp;
      acfg_pkg::ACFG_PAT_CUSTOM: d.word = custom_word;
      // Unused codes fall back to conversion data
      default: d.word = sample_word;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign word_q = q.word;

endmodule

`default_nettype wire

// ### rtl/acfg_pkg.sv
package acfg_pkg;

  typedef enum logic [2:0] {
    ACFG_ST_IDLE = 3'b001,
    ACFG_ST_SHIFT = 3'b010,
    ACFG_ST_END = 3'b100
  } acfg_ctrl_state_t;

  typedef enum logic [2:0] {
    ACFG_PAT_NORMAL = 3'h0,
    ACFG_PAT_ZEROS = 3'h1,
    ACFG_PAT_ONES = 3'h2,
    ACFG_PAT_TOGGLE = 3'h3,
    ACFG_PAT_RAMP = 3'h4,
    ACFG_PAT_CUSTOM = 3'h5
  } acfg_pattern_t;

endpackage

// ### verification/acfg_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module acfg_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  input wire logic serial_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic overrange_or_readback_pin
);
  logic clk_q;
  logic [4:0] falls_q;
  logic [4:0] falls_d;

  // Falls are counted from the registered link, so a glitch-free clock is assumed
  always_comb begin
    falls_d = falls_q;
    if (serial_select_n) begin
      falls_d = 5'h00;
    end else if (clk_q && !serial_clock) begin
      falls_d = falls_q + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      falls_q <= 5'h00;
      clk_q <= 1'b1;
    end else begin
      falls_q <= falls_d;
      clk_q <= serial_clock;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_high_half;
    serial_clock [*4] ##1 !serial_clock;
  endsequence
  sequence s_low_half;
    (!serial_clock) [*4] ##1 serial_clock;
  endsequence

  AST_IDLE_CLK: assert property (serial_select_n |-> serial_clock)
    else $error("serial clock low outside a frame");
  AST_FRAME_START: assert property ($fell(serial_select_n) |-> s_high_half)
    else $error("first fall not one half period after select");
  AST_LOW_HALF: assert property ($fell(serial_clock) |-> s_low_half)
    else $error("serial clock low phase has wrong length");
  AST_HIGH_HALF: assert property ($rose(serial_clock) && !serial_select_n |-> serial_clock [*4])
    else $error("serial clock high phase too short");
  AST_DATA_HOLD: assert property (!serial_select_n && !serial_clock |-> $stable(serial_data_in))
    else $error("serial data moved while clock low");
  AST_SEL_END: assert property ($rose(serial_select_n) |-> serial_clock && $past(serial_clock, 4))
    else $error("select released too close to a clock edge");
  AST_FRAME_LEN: assert property ($fell(serial_select_n) |-> ##132 $rose(serial_select_n))
    else $error("frame length wrong");
  AST_FALL_COUNT: assert property ($rose(serial_select_n) |-> falls_q == 5'h10)
    else $error("frame did not carry sixteen falls");
endmodule

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acfg_params.svh"

module tb_top;
  logic aclk, aresetn, overrange_in, strap, awvalid, awready, wvalid, wready;
  logic bvalid, bready, arvalid, arready, rvalid, rready, perf2;
  logic ckdrv, dtdrv, twos, corr, dpath, stby, pdn, obuf;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp, perf1;
  logic [11:0] adc, data_word, t0;
  logic [5:0] swing;
  logic [3:0] gain;
  logic [7:0] d;
  logic [20:0] cfg;
  logic [5:0] codes [6] = '{6'h00, 6'h1B, 6'h32, 6'h14, 6'h3E, 6'h0F};
  int mismatches, samples_checked;
  assign cfg = {swing, perf1, perf2, gain, ckdrv, dtdrv, twos, corr, dpath, stby, pdn, obuf};

  acfg_if bus_if();
  acfg_ctrl acfg_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(bus_if));
  acfg_device acfg_device_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus_if),
    .adc_sample(adc), .overrange_in(overrange_in), .format_strap_pin(strap),
    .data_word(data_word), .swing_code(swing), .first_performance_setting(perf1),
    .second_performance_setting(perf2), .gain_code(gain), .clock_buffer_drive(ckdrv),
    .data_buffer_drive(dtdrv), .twos_complement(twos), .dc_correction_enable(corr),
    .digital_path_enable(dpath), .standby(stby), .power_down(pdn), .output_buffer_off(obuf));
  acfg_monitor acfg_monitor_inst (.aclk(aclk), .aresetn(aresetn),
    .serial_select_n(bus_if.serial_select_n), .serial_clock(bus_if.serial_clock),
    .serial_data_in(bus_if.serial_data_in),
    .overrange_or_readback_pin(bus_if.overrange_or_readback_pin));

  always #4 aclk = ~aclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Serial write through the controller, waiting for the frame to finish
  task automatic sw(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] s;
    logic [1:0] r;
    axi_wr({28'h0000000, `ACFG_AXI_CMD}, {16'h0000, a, v}, r);
    s = 32'h00000001;
    while (s[0]) axi_rd({28'h0000000, `ACFG_AXI_STATUS}, s, r);
    repeat (3) @(posedge aclk);
  endtask

  task automatic sr(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] s;
    logic [1:0] r;
    sw(a, 8'h00);
    axi_rd({28'h0000000, `ACFG_AXI_STATUS}, s, r);
    v = s[15:8];
  endtask

  task automatic t_reset;
    logic [31:0] v;
    logic [1:0] r;
    chk(cfg, 21'h000000);
    overrange_in <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(bus_if.overrange_or_readback_pin, 1'b1);
    overrange_in <= 1'b0;
    axi_rd(32'h00000008, v, r);
    chk(r, `ACFG_RESP_SLVERR);
    chk(v, 32'h00000000);
    // Writes to status are accepted and ignored, so no frame may start
    axi_wr({28'h0000000, `ACFG_AXI_STATUS}, 32'h0000FFFF, r);
    chk(r, `ACFG_RESP_OKAY);
    axi_rd({28'h0000000, `ACFG_AXI_STATUS}, v, r);
    chk({r, v[15:0]}, {`ACFG_RESP_OKAY, 16'h0000});
    axi_rd({28'h0000000, `ACFG_AXI_CMD}, v, r);
    chk({r, v[15:0]}, {`ACFG_RESP_OKAY, 16'h0000});
    axi_wr(32'h00000008, 32'h00000000, r);
    chk(r, `ACFG_RESP_SLVERR);
    $display("done reset");
  endtask

  task automatic t_fields;
    sw(8'h26, 8'h03);
    chk({ckdrv, dtdrv}, 2'h3);
    sw(8'h26, 8'h02);
    chk({ckdrv, dtdrv}, 2'h2);
    sw(8'h3D, 8'hE0);
    chk({twos, corr}, 2'h1);
    sw(8'h3D, 8'h80);
    chk({twos, corr}, 2'h2);
    strap <= 1'b1;
    sw(8'h3D, 8'h00);
    chk(twos, 1'b1);
    sw(8'h3D, 8'h40);
    chk(twos, 1'b1);
    strap <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(twos, 1'b0);
    // Codes 01 and 10 are forbidden to the controller, so only 00 and 11 are tried
    sw(8'h03, 8'h00);
    chk(perf1, 2'h0);
    sw(8'h03, 8'h03);
    chk(perf1, 2'h3);
    sw(8'h4A, 8'h01);
    chk(perf2, 1'b1);
    $display("done fields");
  endtask

  task automatic t_gain;
    sw(8'h42, 8'h08);
    sw(8'h25, 8'hC0);
    chk({dpath, gain}, 5'h1C);
    sw(8'h25, 8'h50);
    chk(gain, 4'h5);
    sw(8'h25, 8'hC8);
    chk(gain, 4'h0);
    sw(8'h25, 8'hD0);
    chk(gain, 4'h0);
    sw(8'h25, 8'h50);
    sw(8'h42, 8'h04);
    chk({stby, gain}, 5'h10);
    $display("done gain");
  endtask

  task automatic t_swing;
    sw(8'h01, 8'h6C);
    chk(swing, 6'h00);
    sw(8'h43, 8'h53);
    chk({pdn, obuf, swing}, 8'hDB);
    foreach (codes[i]) begin
      sw(8'h01, {codes[i], 2'h0});
      chk(swing, codes[i]);
    end
    sw(8'h01, 8'h04);
    chk(swing, 6'h00);
    sw(8'h43, 8'h00);
    $display("done swing");
  endtask

  task automatic t_pattern;
    sw(8'h3D, 8'h80);
    sw(8'h25, 8'h00);
    chk(data_word, {~adc[11], adc[10:0]});
    sw(8'h3D, 8'hC0);
    chk(data_word, adc);
    sw(8'h25, 8'h01);
    chk(data_word, 12'h000);
    sw(8'h25, 8'h02);
    chk(data_word, 12'hFFF);
    sw(8'h25, 8'h06);
    chk(data_word, adc);
    sw(8'h25, 8'h03);
    t0 = data_word;
    @(posedge aclk);
    chk(t0 ^ data_word, 12'hFFF);
    chk(t0 === 12'h555 || t0 === 12'hAAA, 1'b1);
    sw(8'h25, 8'h04);
    t0 = data_word;
    repeat (4) @(posedge aclk);
    chk(data_word, t0 + 12'h001);
    sw(8'h3F, 8'hA5);
    sw(8'h40, 8'hC0);
    sw(8'h25, 8'h05);
    chk(data_word, 12'hA5C);
    $display("done pattern");
  endtask

  task automatic t_readback;
    sw(8'h00, 8'h01);
    sr(8'h3F, d);
    chk(d, 8'hA5);
    sw(8'h26, 8'h00);
    sr(8'h26, d);
    chk({ckdrv, d}, 9'h102);
    sr(8'h00, d);
    chk(d, 8'h00);
    sw(8'h00, 8'h02);
    chk(cfg, 21'h000000);
    overrange_in <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(bus_if.overrange_or_readback_pin, 1'b1);
    overrange_in <= 1'b0;
    sw(8'h00, 8'h01);
    sr(8'h3F, d);
    chk(d, 8'h00);
    sw(8'h00, 8'h00);
    $display("done readback");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    {aclk, aresetn, overrange_in, strap, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    adc = 12'h3C5;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_fields;
    t_gain;
    t_swing;
    t_pattern;
    t_readback;
    conclude;
  end

  // Some fifty frames of about 150 cycles each fit well inside this span
  initial begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    conclude;
  end
endmodule

`default_nettype wire
